// file: hw/wdr_pin_sync.sv
// Three-stage pin synchroniser for jumpers and supply monitors
`timescale 1ns/1ps
module wdr_pin_sync #(
	parameter int N = 4
) (
	// Clock and reset
	input  wire logic         clk_sys,
	input  wire logic         rst_b,
	// Raw pins
	input  wire logic [N-1:0] pin_in,
	// Filtered levels
	wdr_sync_if.src           sync_o
);
	logic      [N-1:0] s1_ff;
	logic      [N-1:0] s2_ff;
	logic      [N-1:0] s3_ff;
	wire logic [N-1:0] lvl;

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			s1_ff <= '0;
			s2_ff <= '0;
			s3_ff <= '0;
		end else begin
			s1_ff <= pin_in;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
		end
	end

	// Level changes only once stages two and three agree
	genvar g;
	generate
		for (g = 0; g < N; g++) begin : g_bit
			logic lvl_ff;
			always_ff @(posedge clk_sys or negedge rst_b) begin
				if (!rst_b) begin
					lvl_ff <= 1'b0;
				end else if (s2_ff[g] == s3_ff[g]) begin
					lvl_ff <= s3_ff[g];
				end
			end
			assign lvl[g] = lvl_ff;
		end
	endgenerate

	// Bit order follows the pin concatenation at the instance
	assign sync_o.mode_wd     = lvl[0];
	assign sync_o.low_rail_en = lvl[1];
	assign sync_o.fail_5v     = lvl[2];
	assign sync_o.fail_3v3    = lvl[3];
endmodule : wdr_pin_sync

// file: hw/wdr_pkg.sv
// Package: constants for the watchdog and board reset block
package wdr_pkg;
	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [15:0] GEN_OUT_ADDR     = 16'h0437;
	localparam int          GEN_OUT_WD_BIT   = 6;
	localparam logic [7:0]  GEN_OUT_RST      = 8'h40;
	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam longint      CLK_HZ           = 200000000;
	localparam longint      WD_TIMEOUT_MS    = 1500;
	localparam longint      WD_TIMEOUT_CYC   = (WD_TIMEOUT_MS * CLK_HZ) / 1000;
	localparam int          RST_PULSE_US     = 100;
	localparam int          RST_PULSE_CYC    = int'((RST_PULSE_US * CLK_HZ) / 1000000);
	localparam int          SYNC_STAGES      = 3;
	// ----------------------------------------------------------------
	// Sequencer states
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		WDR_IDLE  = 3'b001,
		WDR_ARMED = 3'b010,
		WDR_RESET = 3'b100
	} wdr_state_e;
endpackage : wdr_pkg

// file: hw/wdr_sync_if.sv
// Interface: synchronised pin levels passed to the watchdog core
`timescale 1ns/1ps
interface wdr_sync_if;
	logic mode_wd;
	logic low_rail_en;
	logic fail_5v;
	logic fail_3v3;
	modport src (output mode_wd, output low_rail_en, output fail_5v, output fail_3v3);
	modport dst (input mode_wd, input low_rail_en, input fail_5v, input fail_3v3);
endinterface : wdr_sync_if

// file: hw/wdr_top.sv
// Watchdog timer and board hardware reset generator
// Function
// [RQ1] Timer can reset the board only when watchdog mode jumper enables it.
// [RQ2] Writing bit 6 zero at 437H arms a reset about 1.5 s later.
// [RQ3] Writing bit 6 one clears the pending delay; no reset while one.
// [RQ4] Software must toggle bit 6 one then zero within 1.5 s.
// [RQ5] Expiry without refresh asserts the board hardware reset.
// [RQ6] 5 V supply below 4.75 V asserts the board hardware reset.
// [RQ7] With low rail jumper fitted, 3.3 V undervoltage also asserts reset.
// [RQ8] Mode jumper left selects normal reset, right selects watchdog operation.
// [RQ9] Low rail jumper removed means 3.3 V undervoltage input is ignored.
// [RQ10] All sources merge into one reset of minimum width; timer then clears.
`timescale 1ns/1ps
module wdr_top
	import wdr_pkg::*;
#(
	parameter longint TIMEOUT_CYC = wdr_pkg::WD_TIMEOUT_CYC,
	parameter int     PULSE_CYC   = wdr_pkg::RST_PULSE_CYC
) (
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst_b,
	// I/O register port
	input  wire logic [15:0] io_addr,
	input  wire logic        io_wr,
	input  wire logic        io_rd,
	input  wire logic [7:0]  io_wdata,
	output logic      [7:0]  io_rdata,
	// Jumpers, high when in the enabling position
	input  wire logic        watchdog_mode_jumper,
	input  wire logic        low_rail_monitor_jumper,
	// Supply supervisors, high on undervoltage
	input  wire logic        fail_5v,
	input  wire logic        fail_3v3,
	// Board reset and status
	output logic             board_rst_b,
	output logic             wd_pending
);
	import wdr_pkg::*;

	// ----------------------------------------------------------------
	// Pin synchronisation
	// ----------------------------------------------------------------
	// Jumpers share the monitor filter, so a one-cycle jumper glitch cannot arm
	wdr_sync_if sync_if ();

	wdr_pin_sync #(.N(4)) u_sync (
		.clk_sys (clk_sys),
		.rst_b   (rst_b),
		.pin_in  ({fail_3v3, fail_5v, low_rail_monitor_jumper, watchdog_mode_jumper}),
		.sync_o  (sync_if)
	);

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	function automatic logic hit(input logic [15:0] a);
		hit = (a == GEN_OUT_ADDR);
	endfunction : hit

	logic wr_hit;
	logic rd_hit;
	assign wr_hit = io_wr && hit(io_addr);
	assign rd_hit = io_rd && hit(io_addr);

	// ----------------------------------------------------------------
	// General output register
	// ----------------------------------------------------------------
	logic [7:0] general_output_reg_ff;
	logic       wd_bit;

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			general_output_reg_ff <= GEN_OUT_RST;
		end else if (wr_hit) begin
			general_output_reg_ff <= io_wdata;                   // RQ2 RQ3
		end
	end

	// Other addresses read zero, so a stray read never shows a live bit
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			io_rdata <= 8'h00;
		end else if (rd_hit) begin
			io_rdata <= general_output_reg_ff;
		end else begin
			io_rdata <= 8'h00;
		end
	end

	assign wd_bit = general_output_reg_ff[GEN_OUT_WD_BIT];

	// ----------------------------------------------------------------
	// Reset sources
	// ----------------------------------------------------------------
	logic fail_5v_hit;
	logic fail_3v3_hit;
	logic supply_fail;

	assign fail_5v_hit  = sync_if.fail_5v;                           // RQ6
	assign fail_3v3_hit = sync_if.low_rail_en && sync_if.fail_3v3;   // RQ7 RQ9
	assign supply_fail  = fail_5v_hit || fail_3v3_hit;

	// ----------------------------------------------------------------
	// Watchdog requests
	// ----------------------------------------------------------------
	logic arm_req;
	logic disarm_req;

	// Either the jumper going low or the bit going high drops a pending timeout
	assign arm_req    = sync_if.mode_wd && !wd_bit;                  // RQ1 RQ8 RQ2
	assign disarm_req = !sync_if.mode_wd || wd_bit;                  // RQ1 RQ3

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	wdr_state_e  state_ff;
	wdr_state_e  nxt_state;
	logic [31:0] wd_cnt_ff;
	logic [31:0] pulse_cnt_ff;
	logic        expired;
	logic        pulse_done;

	localparam logic [31:0] TO_LAST    = 32'(TIMEOUT_CYC - 1);
	localparam logic [31:0] PULSE_LAST = 32'(PULSE_CYC - 1);

	assign expired    = (wd_cnt_ff == TO_LAST);
	assign pulse_done = (pulse_cnt_ff == PULSE_LAST);

	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			WDR_IDLE: begin
				if (supply_fail) begin
					nxt_state = WDR_RESET;                   // RQ6 RQ7
				end else if (arm_req) begin
					nxt_state = WDR_ARMED;                   // RQ2
				end
			end
			WDR_ARMED: begin
				if (supply_fail) begin
					nxt_state = WDR_RESET;
				end else if (disarm_req) begin
					nxt_state = WDR_IDLE;                    // RQ3 RQ1
				end else if (expired) begin
					nxt_state = WDR_RESET;                   // RQ5
				end
			end
			WDR_RESET: begin
				// Holds while a supply stays low, then for the full width
				if (!supply_fail && pulse_done) begin
					nxt_state = WDR_IDLE;                    // RQ10
				end
			end
			default: begin
				nxt_state = WDR_IDLE;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			state_ff <= WDR_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// ----------------------------------------------------------------
	// Watchdog timer
	// ----------------------------------------------------------------
	logic wd_run;
	assign wd_run = (state_ff == WDR_ARMED) && (nxt_state == WDR_ARMED);

	// Counts only while armed; any other state, board reset included, clears it
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			wd_cnt_ff <= 32'h0000_0000;
		end else if (wd_run) begin
			wd_cnt_ff <= wd_cnt_ff + 32'h0000_0001;                // RQ2
		end else begin
			wd_cnt_ff <= 32'h0000_0000;                            // RQ3 RQ10
		end
	end

	// ----------------------------------------------------------------
	// Reset pulse width
	// ----------------------------------------------------------------
	// Restarts while a supply is low, so the width counts from recovery
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			pulse_cnt_ff <= 32'h0000_0000;
		end else if (state_ff != WDR_RESET || supply_fail) begin
			pulse_cnt_ff <= 32'h0000_0000;
		end else if (!pulse_done) begin
			pulse_cnt_ff <= pulse_cnt_ff + 32'h0000_0001;          // RQ10
		end
	end

	// ----------------------------------------------------------------
	// Board reset output
	// ----------------------------------------------------------------
	// Taken from the next state so the pin moves with the state register
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			board_rst_b <= 1'b0;
		end else begin
			board_rst_b <= (nxt_state != WDR_RESET);                // RQ5 RQ6 RQ10
		end
	end

	// ----------------------------------------------------------------
	// Pending status
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			wd_pending <= 1'b0;
		end else begin
			wd_pending <= (nxt_state == WDR_ARMED);
		end
	end
endmodule : wdr_top

// file: test/tb_wdr_top.sv
// Testbench: self-checking run of the watchdog and board reset block
`timescale 1ns/1ps
module tb_wdr_top;
	import wdr_pkg::*;
	localparam int TO = 200;
	localparam int PW = 8;
	logic        clk_sys, rst_b, io_wr, io_rd, watchdog_mode_jumper, low_rail_monitor_jumper, fail_5v, fail_3v3;
	logic [15:0] io_addr;
	logic [7:0]  io_wdata, io_rdata, got;
	logic        board_rst_b, wd_pending;
	int          n_mismatch, compares, lo;
	wdr_top #(.TIMEOUT_CYC(TO), .PULSE_CYC(PW)) dut (.clk_sys(clk_sys), .rst_b(rst_b), .io_addr(io_addr),
		.io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
		.watchdog_mode_jumper(watchdog_mode_jumper), .low_rail_monitor_jumper(low_rail_monitor_jumper),
		.fail_5v(fail_5v), .fail_3v3(fail_3v3), .board_rst_b(board_rst_b), .wd_pending(wd_pending));
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : cyc
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
		compares++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD %s expected %0h seen %0h", what, exp, seen);
		end
	endtask : chk
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		io_addr = a;
		io_wdata = d;
		io_wr = 1'b1;
		cyc(1);
		io_wr = 1'b0;
		cyc(1);
	endtask : wr
	task automatic rd(input logic [15:0] a);
		io_addr = a;
		io_rd = 1'b1;
		cyc(1);
		io_rd = 1'b0;
		got = io_rdata;
		cyc(1);
	endtask : rd
	task automatic watch(input int n);
		lo = 0;
		repeat (n) begin
			cyc(1);
			lo += (board_rst_b === 1'b0);
		end
	endtask : watch
	task automatic test_done;
		if (n_mismatch == 0 && compares > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : test_done
	task automatic t_regs;
		rd(GEN_OUT_ADDR);
		chk("reg_reset", GEN_OUT_RST, got);
		chk("rst_idle", 1, board_rst_b);
		wr(16'h0438, 8'h00);
		rd(16'h0438);
		chk("rd_unmapped", 8'h00, got);
		rd(GEN_OUT_ADDR);
		chk("reg_kept", GEN_OUT_RST, got);
	endtask : t_regs
	task automatic t_normal;
		wr(GEN_OUT_ADDR, 8'h00);
		watch(TO + 40);
		chk("normal_lo", 0, lo);
		chk("normal_pend", 0, wd_pending);
		wr(GEN_OUT_ADDR, 8'h40);
	endtask : t_normal
	task automatic t_watchdog;
		watchdog_mode_jumper = 1'b1;
		cyc(6);
		wr(GEN_OUT_ADDR, 8'h00);
		chk("armed", 1, wd_pending);
		repeat (3) begin
			watch(TO / 2);
			chk("refresh_lo", 0, lo);
			wr(GEN_OUT_ADDR, 8'h40);
			wr(GEN_OUT_ADDR, 8'h00);
		end
		watch(TO + PW + 20);
		chk("expire_lo", 1, lo >= PW && lo <= PW + 2);
		wr(GEN_OUT_ADDR, 8'h40);
		watch(TO + 20);
		chk("cleared_lo", 0, lo);
	endtask : t_watchdog
	task automatic t_disarm;
		wr(GEN_OUT_ADDR, 8'h00);
		chk("rearm", 1, wd_pending);
		watchdog_mode_jumper = 1'b0;
		watch(TO + 20);
		chk("jumper_off_lo", 0, lo);
		chk("jumper_off_pend", 0, wd_pending);
		watchdog_mode_jumper = 1'b1;
		cyc(6);
		chk("jumper_on_pend", 1, wd_pending);
		rst_b = 1'b0;
		cyc(2);
		chk("mid_rst_lo", 0, board_rst_b);
		chk("mid_rst_pend", 0, wd_pending);
		rst_b = 1'b1;
		cyc(1);
		chk("mid_rst_hi", 1, board_rst_b);
		rd(GEN_OUT_ADDR);
		chk("mid_rst_reg", GEN_OUT_RST, got);
		watch(TO + 20);
		chk("mid_rst_quiet", 0, lo);
	endtask : t_disarm
	task automatic t_supply;
		fail_5v = 1'b1;
		watch(20);
		chk("fail5_lo", 1, lo >= 14);
		fail_5v = 1'b0;
		watch(30);
		chk("fail5_tail", 1, lo >= PW && lo <= PW + 8);
		fail_3v3 = 1'b1;
		watch(30);
		chk("fail3_off", 0, lo);
		low_rail_monitor_jumper = 1'b1;
		watch(20);
		chk("fail3_on", 1, lo >= 14);
		fail_3v3 = 1'b0;
		watch(40);
		chk("fail3_end", 1, board_rst_b);
	endtask : t_supply
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	initial begin
		#100000;
		n_mismatch++;
		test_done();
	end
	initial begin
		{rst_b, io_wr, io_rd, watchdog_mode_jumper, low_rail_monitor_jumper, fail_5v, fail_3v3} = '0;
		io_addr = '0;
		io_wdata = '0;
		n_mismatch = 0;
		compares = 0;
		cyc(2);
		rst_b = 1'b1;
		cyc(6);
		t_regs();
		t_normal();
		t_watchdog();
		t_disarm();
		t_supply();
		test_done();
	end
endmodule : tb_wdr_top

// file: test/wdr_top_props.sv
// Checker: timing properties of the watchdog and board reset block
`timescale 1ns/1ps
module wdr_top_props
	import wdr_pkg::*;
#(
	parameter longint TIMEOUT_CYC = 200,
	parameter int     PULSE_CYC   = 8
) (
	input wire logic        clk_sys,
	input wire logic        rst_b,
	input wire logic [15:0] io_addr,
	input wire logic        io_wr,
	input wire logic        io_rd,
	input wire logic [7:0]  io_wdata,
	input wire logic [7:0]  io_rdata,
	input wire logic        watchdog_mode_jumper,
	input wire logic        low_rail_monitor_jumper,
	input wire logic        fail_5v,
	input wire logic        fail_3v3,
	input wire logic        board_rst_b,
	input wire logic        wd_pending
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	logic [31:0] pend_cnt_ff;
	// Cycles spent armed, to bound the timeout from both sides
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) pend_cnt_ff <= '0;
		else pend_cnt_ff <= wd_pending ? pend_cnt_ff + 32'h1 : '0;
	end
	AST_NORMAL_MODE: assert property (!watchdog_mode_jumper [*7] |-> !wd_pending) else $error("armed in normal mode");
	AST_ARM: assert property (io_wr && io_addr == GEN_OUT_ADDR && !io_wdata[6] && watchdog_mode_jumper
		&& $past(watchdog_mode_jumper, 6) && board_rst_b && !fail_5v |-> ##[1:3] wd_pending) else $error("not armed");
	AST_BIT6_ONE: assert property (io_wr && io_addr == GEN_OUT_ADDR && io_wdata[6] |-> ##[1:3] !wd_pending)
		else $error("delay not cleared");
	AST_TIMEOUT_MAX: assert property (wd_pending |-> pend_cnt_ff <= TIMEOUT_CYC + 3) else $error("timeout late");
	AST_TIMEOUT_MIN: assert property ($fell(board_rst_b) && !fail_5v && !fail_3v3 |-> pend_cnt_ff >= TIMEOUT_CYC - 3)
		else $error("timeout early");
	AST_FAIL_5V: assert property (fail_5v [*8] |-> !board_rst_b) else $error("no reset on 5v fail");
	AST_FAIL_3V3: assert property ((low_rail_monitor_jumper && fail_3v3) [*8] |-> !board_rst_b)
		else $error("no reset on 3v3 fail");
	// Eight matches the short pulse width used in simulation
	AST_PULSE_MIN: assert property ($fell(board_rst_b) |-> !board_rst_b [*8]) else $error("pulse short");
	AST_RD_UNMAPPED: assert property (io_rd && io_addr != GEN_OUT_ADDR |=> io_rdata == 8'h00) else $error("rd unmapped");
endmodule : wdr_top_props
bind wdr_top wdr_top_props #(.TIMEOUT_CYC(TIMEOUT_CYC), .PULSE_CYC(PULSE_CYC)) u_props (.clk_sys(clk_sys),
	.rst_b(rst_b), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
	.watchdog_mode_jumper(watchdog_mode_jumper), .low_rail_monitor_jumper(low_rail_monitor_jumper),
	.fail_5v(fail_5v), .fail_3v3(fail_3v3), .board_rst_b(board_rst_b), .wd_pending(wd_pending));
